// ==== common/dcr_pkg.sv ====
// Package: register map, field layout and types of the config register bank
package dcr_pkg;

    // ------------------------------------------------------------------
    // Address window and register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] RANGE_LO    = 16'h0800; // First decoded address
    localparam logic [15:0] RANGE_HI    = 16'h08FF; // Last decoded address
    localparam logic [15:0] OFF_MODE    = 16'h0800; // Mode and pin config
    localparam logic [15:0] OFF_TSPRE   = 16'h0804; // Timestamp prescaler
    localparam logic [15:0] OFF_SCRATCH = 16'h0808; // Scratch test word
    localparam logic [15:0] OFF_ECC     = 16'h080C; // Error correction/delay
    localparam logic [15:0] OFF_DIFLAG  = 16'h0820; // Device interrupt flags
    localparam logic [15:0] OFF_PCFLAG  = 16'h0824; // Protocol core flags
    localparam logic [15:0] OFF_IEN     = 16'h0830; // Interrupt enable mask

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_MODE    = 32'hC800_0468;
    localparam logic [31:0] RST_TSPRE   = 32'h0000_0002;
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [31:0] RST_IEN     = 32'h0FFF_FFFF;

    // ------------------------------------------------------------------
    // Writable and sleep-retained bit masks
    // ------------------------------------------------------------------
    // Mode register: bits 26:24, 20, 12, 5, 4 are reserved read-only
    localparam logic [31:0] WMASK_MODE  = 32'hF8EF_EFCF;
    // Mode bits kept across sleep: 0,1,8-11,13-15,19,21-23,30,31
    localparam logic [31:0] KEEP_MODE   = 32'hC0E8_EF03;
    // Flag bits kept across sleep: 18, 19, 21
    localparam logic [31:0] KEEP_DIFLAG = 32'h002C_0000;
    // Enable bits kept across sleep: 14, 15
    localparam logic [31:0] KEEP_IEN    = 32'h0000_C000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int WAKE_HI   = 31; // Wake-edge select upper bit
    localparam int WAKE_LO   = 30; // Wake-edge select lower bit
    localparam int ST_IRQ    = 0;  // Status: live interrupt level
    localparam int ST_SPIERR = 1;  // Status: unmasked serial-port fault
    localparam int ST_INTERR = 2;  // Status: unmasked internal fault

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Wake-pin edge selection
    typedef enum logic [1:0] {
        WAKE_OFF  = 2'h0,
        WAKE_RISE = 2'h1,
        WAKE_FALL = 2'h2,
        WAKE_BOTH = 2'h3
    } dcr_wake_e;

    // Register access request from the serial-port front end
    typedef struct packed {
        logic        wr;    // Write strobe, one cycle
        logic        rd;    // Read strobe, one cycle
        logic [15:0] addr;  // Byte address
        logic [31:0] wdata; // Write data
    } dcr_req_s;

endpackage

// ==== src/dcr_wake_det.sv ====
// Wake pin synchroniser and selectable edge detector
`timescale 1ns/1ns
module dcr_wake_det (
    input  wire logic             i_sys_clk,  // System clock
    input  wire logic             i_resetn,   // Async reset, active low
    input  wire logic             i_wake_pin, // Asynchronous wake pin
    input  wire dcr_pkg::dcr_wake_e i_sel,    // Edge selection
    output logic                  o_wake      // One-cycle wake pulse
);
    // ------------------------------------------------------------------
    // Synchroniser and edge history
    // ------------------------------------------------------------------
    logic meta_ff;  // First stage, read only by sync_ff
    logic sync_ff;  // Second stage
    logic prev_ff;  // Previous synced level
    logic rise;     // Rising edge seen
    logic fall;     // Falling edge seen

    // Two-stage synchroniser plus history
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= i_wake_pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;

    // Edge select decode
    always_comb begin
        case (i_sel)
            dcr_pkg::WAKE_OFF:  o_wake = 1'b0;
            dcr_pkg::WAKE_RISE: o_wake = rise;
            dcr_pkg::WAKE_FALL: o_wake = fall;
            dcr_pkg::WAKE_BOTH: o_wake = rise | fall;
            default:            o_wake = 1'b0;
        endcase
    end

    // Selection honoured against the synced edges
    property p_wake_sel;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_wake |-> (i_sel == dcr_pkg::WAKE_BOTH) ||
                   (i_sel == dcr_pkg::WAKE_RISE && sync_ff) ||
                   (i_sel == dcr_pkg::WAKE_FALL && !sync_ff);
    endproperty
    a_wake_sel: assert property (p_wake_sel)
        else $error("wake pulse does not match edge selection");
endmodule

// ==== src/dcr_addr_dec.sv ====
// Address decoder for the configuration register window
`timescale 1ns/1ns
module dcr_addr_dec (
    input  wire logic [15:0] i_addr,   // Byte address
    output logic             o_in_rng, // Address inside window
    output logic [6:0]       o_hit     // One-hot register select
);
    // ------------------------------------------------------------------
    // Window check and register match
    // ------------------------------------------------------------------
    localparam logic [15:0] OFFS [7] = '{dcr_pkg::OFF_MODE,
        dcr_pkg::OFF_TSPRE, dcr_pkg::OFF_SCRATCH, dcr_pkg::OFF_ECC,
        dcr_pkg::OFF_DIFLAG, dcr_pkg::OFF_PCFLAG, dcr_pkg::OFF_IEN};

    // Inside 0800..08FF
    assign o_in_rng = (i_addr >= dcr_pkg::RANGE_LO) &&
                      (i_addr <= dcr_pkg::RANGE_HI);

    // One comparator per assigned register
    for (genvar g = 0; g < 7; g++) begin : g_hit
        assign o_hit[g] = o_in_rng && (i_addr == OFFS[g]);
    end
endmodule

// ==== src/dcr_reg_bank.sv ====
// Device configuration register bank with sleep retention
`timescale 1ns/1ns
module dcr_reg_bank (
    input  wire logic              i_sys_clk,     // System clock
    input  wire logic              i_resetn,      // Async reset, low
    input  wire dcr_pkg::dcr_req_s i_req,         // Register access
    output logic [31:0]            o_rdata,       // Read data, registered
    output logic                   o_rvalid,      // Read data valid pulse
    input  wire logic              i_sleep,       // Sleep entry pulse
    input  wire logic [31:0]       i_dev_flags,   // Flag set events
    input  wire logic [31:0]       i_core_flags,  // Protocol core flags
    input  wire logic              i_flag_clr,    // Clear flags pulse
    input  wire logic              i_int_fault,   // Internal fault level
    input  wire logic              i_spi_fault,   // Serial fault level
    input  wire logic              i_wake_pin,    // Async wake pin
    output logic [2:0]             o_status,      // Status bits 2:0
    output logic [31:0]            o_mode_cfg,    // Mode register value
    output logic                   o_wake,        // Wake pulse
    output logic                   o_irq          // Combined interrupt
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [31:0] mode_ff;     // Mode and pin configuration
    logic [31:0] tspre_ff;    // Timestamp prescaler
    logic [31:0] scratch_ff;  // Scratch test word
    logic [31:0] ecc_ff;      // Error correction and delay
    logic [31:0] diflag_ff;   // Device interrupt flags
    logic [31:0] pcflag_ff;   // Protocol core flags snapshot
    logic [31:0] ien_ff;      // Interrupt enable mask
    logic [2:0]  status_ff;   // Status bits
    logic        in_rng;      // Address in window
    logic [6:0]  hit;         // Register select
    logic [31:0] nxt_rdata;   // Read mux result
    logic        wr_ok;       // Write inside window

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    dcr_addr_dec u_dec (
        .i_addr   (i_req.addr),
        .o_in_rng (in_rng),
        .o_hit    (hit)
    );

    assign wr_ok = i_req.wr && in_rng;

    // Merge write data under a mask of writable bits
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] msk);
        merge = (old_v & ~msk) | (new_v & msk);
    endfunction

    // ------------------------------------------------------------------
    // Mode register: mixed access, sleep retention
    // ------------------------------------------------------------------
    // Reserved bits never written; sleep returns the non-retained bits to their reset values
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_ff <= dcr_pkg::RST_MODE;
        end else if (i_sleep) begin
            mode_ff <= merge(dcr_pkg::RST_MODE, mode_ff,
                             dcr_pkg::KEEP_MODE);
        end else if (wr_ok && hit[0]) begin
            mode_ff <= merge(mode_ff, i_req.wdata,
                             dcr_pkg::WMASK_MODE);
        end
    end

    // ------------------------------------------------------------------
    // Plain read/write registers
    // ------------------------------------------------------------------
    // Prescaler, scratch and delay words
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tspre_ff   <= dcr_pkg::RST_TSPRE;
            scratch_ff <= dcr_pkg::RST_ZERO;
            ecc_ff     <= dcr_pkg::RST_ZERO;
        end else begin
            if (wr_ok && hit[1]) begin
                tspre_ff <= i_req.wdata;
            end
            if (wr_ok && hit[2]) begin
                scratch_ff <= i_req.wdata;
            end
            if (wr_ok && hit[3]) begin
                ecc_ff <= i_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enable mask with sleep retention
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ien_ff <= dcr_pkg::RST_IEN;
        end else if (i_sleep) begin
            ien_ff <= merge(dcr_pkg::RST_IEN, ien_ff,
                            dcr_pkg::KEEP_IEN);
        end else if (wr_ok && hit[6]) begin
            ien_ff <= i_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Device flags: hardware set, read-only to host
    // ------------------------------------------------------------------
    // Set wins over clear and sleep; sleep drops all but retained bits and new sets
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            diflag_ff <= dcr_pkg::RST_ZERO;
        end else if (i_sleep) begin
            diflag_ff <= (diflag_ff & dcr_pkg::KEEP_DIFLAG)
                         | i_dev_flags;
        end else if (i_flag_clr) begin
            diflag_ff <= i_dev_flags;
        end else begin
            diflag_ff <= diflag_ff | i_dev_flags;
        end
    end

    // Core flags follow the core; host writes have no effect
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pcflag_ff <= dcr_pkg::RST_ZERO;
        end else begin
            pcflag_ff <= i_core_flags;
        end
    end

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    // Combined interrupt from enabled device flags or any core flag
    assign o_irq = |(diflag_ff & ien_ff) | (|pcflag_ff);

    // Status word tracks irq and fault levels
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_ff <= 3'h0;
        end else begin
            status_ff[dcr_pkg::ST_IRQ]    <= o_irq;
            status_ff[dcr_pkg::ST_SPIERR] <= i_spi_fault;
            status_ff[dcr_pkg::ST_INTERR] <= i_int_fault;
        end
    end

    assign o_status   = status_ff;
    assign o_mode_cfg = mode_ff;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unassigned locations return zero
    always_comb begin
        case (hit)
            7'h01:   nxt_rdata = mode_ff;
            7'h02:   nxt_rdata = tspre_ff;
            7'h04:   nxt_rdata = scratch_ff;
            7'h08:   nxt_rdata = ecc_ff;
            7'h10:   nxt_rdata = diflag_ff;
            7'h20:   nxt_rdata = pcflag_ff;
            7'h40:   nxt_rdata = ien_ff;
            default: nxt_rdata = dcr_pkg::RST_ZERO;
        endcase
    end

    // Registered read data, one cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata  <= dcr_pkg::RST_ZERO;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                o_rdata <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------------
    dcr_wake_det u_wake (
        .i_sys_clk  (i_sys_clk),
        .i_resetn   (i_resetn),
        .i_wake_pin (i_wake_pin),
        .i_sel      (dcr_pkg::dcr_wake_e'(
                     mode_ff[dcr_pkg::WAKE_HI:dcr_pkg::WAKE_LO])),
        .o_wake     (o_wake)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_irq_stat;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        ##1 o_status[dcr_pkg::ST_IRQ] == $past(o_irq);
    endproperty
    a_irq_stat: assert property (p_irq_stat)
        else $error("status bit 0 does not follow interrupt level");

    property p_int_stat;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_int_fault |=> o_status[dcr_pkg::ST_INTERR];
    endproperty
    a_int_stat: assert property (p_int_stat)
        else $error("internal fault not shown in status");

    property p_spi_stat;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        !i_spi_fault |=> !o_status[dcr_pkg::ST_SPIERR];
    endproperty
    a_spi_stat: assert property (p_spi_stat)
        else $error("serial fault status set without fault");

    property p_out_rng;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_req.rd && (i_req.addr < dcr_pkg::RANGE_LO ||
                      i_req.addr > dcr_pkg::RANGE_HI))
        |=> o_rvalid && o_rdata == 32'h0000_0000;
    endproperty
    a_out_rng: assert property (p_out_rng)
        else $error("read outside window returned data");

    property p_rsvd_zero;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_req.rd && i_req.addr == 16'h0814)
        |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved location read nonzero");

    property p_mode_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_sleep |=> (mode_ff & dcr_pkg::KEEP_MODE) ==
                    ($past(mode_ff) & dcr_pkg::KEEP_MODE);
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("mode retained bits lost in sleep");

    property p_flag_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_sleep |=> ((diflag_ff ^ $past(diflag_ff))
                     & dcr_pkg::KEEP_DIFLAG & ~$past(i_dev_flags)) == 0;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("flag retained bits lost in sleep");

    property p_ien_keep;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_sleep |=> (ien_ff & dcr_pkg::KEEP_IEN) ==
                    ($past(ien_ff) & dcr_pkg::KEEP_IEN);
    endproperty
    a_ien_keep: assert property (p_ien_keep)
        else $error("enable retained bits lost in sleep");

    property p_mode_rsvd;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (mode_ff & ~dcr_pkg::WMASK_MODE) ==
        (dcr_pkg::RST_MODE & ~dcr_pkg::WMASK_MODE);
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd)
        else $error("mode reserved bits changed");

    property p_flag_ro;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_req.wr && !i_sleep && !i_flag_clr && i_dev_flags == 0)
        |=> $stable(diflag_ff);
    endproperty
    a_flag_ro: assert property (p_flag_ro)
        else $error("host write altered flag register");

    // Write to an unassigned slot leaves the plain registers alone
    property p_gap_wr;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_req.wr && hit == 7'h00)
        |=> $stable(tspre_ff) && $stable(scratch_ff) && $stable(ecc_ff);
    endproperty
    a_gap_wr: assert property (p_gap_wr)
        else $error("write outside assigned slots changed a register");

    // Scratch word takes the write data one edge later
    property p_scr_wr;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_req.wr && i_req.addr == dcr_pkg::OFF_SCRATCH)
        |=> scratch_ff == $past(i_req.wdata);
    endproperty
    a_scr_wr: assert property (p_scr_wr)
        else $error("scratch write did not land");

    // Disabled wake selection never pulses
    property p_wake_off;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (mode_ff[dcr_pkg::WAKE_HI:dcr_pkg::WAKE_LO] == dcr_pkg::WAKE_OFF)
        |-> !o_wake;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wake pulse while wake detection disabled");
endmodule

// ==== bench/dcr_host_model.sv ====
// Host model: issues register reads and writes toward the bank
`timescale 1ns/1ns
module dcr_host_model (
    input  wire logic         i_sys_clk, // System clock
    input  wire logic [31:0]  i_rdata,   // Read data from the bank
    input  wire logic         i_rvalid,  // Read answer pulse
    output dcr_pkg::dcr_req_s o_req      // Request toward the bank
);
    // ----------------------------------------------------------------
    // Bus idle handling
    // ----------------------------------------------------------------
    initial begin
        o_req = '0;
    end

    // Drop strobes; address and data show the inverse of the last value
    task automatic go_idle();
        o_req.wr    = 1'b0;
        o_req.rd    = 1'b0;
        o_req.addr  = ~o_req.addr;
        o_req.wdata = ~o_req.wdata;
    endtask

    // ----------------------------------------------------------------
    // Transfers: launched on a falling edge, held across one rising edge
    // ----------------------------------------------------------------
    task automatic write_word(input logic [15:0] a, input logic [31:0] d);
        @(negedge i_sys_clk);
        o_req.wr    = 1'b1;
        o_req.addr  = a;
        o_req.wdata = d;
        @(negedge i_sys_clk);
        go_idle();
    endtask

    // Answer is registered, so it stands at the next falling edge
    task automatic read_word(input logic [15:0] a, output logic [31:0] d,
                             output logic ok);
        @(negedge i_sys_clk);
        o_req.rd   = 1'b1;
        o_req.addr = a;
        @(negedge i_sys_clk);
        ok = (i_rvalid === 1'b1);
        d  = i_rdata;
        go_idle();
    endtask
endmodule

// ==== bench/device_config_register_bank_tb.sv ====
// Testbench for the device configuration register bank
`timescale 1ns/1ns
module device_config_register_bank_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic              i_sys_clk;    // 100 MHz clock
    logic              i_resetn;     // Async reset, low
    dcr_pkg::dcr_req_s req;          // Request from host model
    logic [31:0]       o_rdata;      // Read data
    logic              o_rvalid;     // Read answer
    logic              i_sleep;      // Sleep entry pulse
    logic [31:0]       i_dev_flags;  // Flag set events
    logic [31:0]       i_core_flags; // Core flags
    logic              i_flag_clr;   // Flag clear pulse
    logic              i_int_fault;  // Internal fault
    logic              i_spi_fault;  // Serial fault
    logic              i_wake_pin;   // Wake pin
    logic [2:0]        o_status;     // Status bits
    logic [31:0]       o_mode_cfg;   // Mode register
    logic              o_wake;       // Wake pulse
    logic              o_irq;        // Interrupt
    int                error_cnt;    // Mismatches
    int                tests_run;    // Comparisons
    logic [31:0]       wake_cnt;     // Wake pulses seen
    logic [31:0]       v;            // Scratch value
    // Slots inside the window that read zero after reset
    localparam logic [15:0] ZERO_A [7] = '{16'h080C, 16'h0810, 16'h0814,
        16'h081C, 16'h0828, 16'h0834, 16'h08FC};

    // ----------------------------------------------------------------
    // Instances
    // ----------------------------------------------------------------
    dcr_reg_bank DUT (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_req(req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .i_sleep(i_sleep), .i_dev_flags(i_dev_flags),
        .i_core_flags(i_core_flags), .i_flag_clr(i_flag_clr),
        .i_int_fault(i_int_fault), .i_spi_fault(i_spi_fault),
        .i_wake_pin(i_wake_pin), .o_status(o_status),
        .o_mode_cfg(o_mode_cfg), .o_wake(o_wake), .o_irq(o_irq));
    dcr_host_model u_host (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata),
        .i_rvalid(o_rvalid), .o_req(req));

    // Clock, 10 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    // Count wake pulses on the rising edge
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            wake_cnt <= 32'h0000_0000;
        end else if (o_wake === 1'b1) begin
            wake_cnt <= wake_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Compare and report tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string msg);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_word({31'h0000_0000, got}, {31'h0000_0000, exp}, msg);
    endtask

    // Read a register and compare against the expected word
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        u_host.read_word(a, d, ok);
        chk_bit(ok, 1'b1, "read answer");
        chk_word(d, exp, $sformatf("read %h", a));
    endtask

    // One-cycle pulse on a bench input
    task automatic pulse_sleep();
        @(negedge i_sys_clk);
        i_sleep = 1'b1;
        @(negedge i_sys_clk);
        i_sleep = 1'b0;
    endtask

    // Move the wake pin and count pulses over six cycles
    task automatic wake_try(input logic lvl, input logic exp);
        logic [31:0] start;
        @(negedge i_sys_clk);
        start      = wake_cnt;
        i_wake_pin = lvl;
        repeat (6) @(negedge i_sys_clk);
        chk_word(wake_cnt - start, {31'h0000_0000, exp}, "wake pulses");
    endtask

    task automatic test_done();
        $display("TB: comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        test_done();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {i_resetn, i_sleep, i_flag_clr, i_int_fault, i_spi_fault} = '0;
        {i_dev_flags, i_core_flags} = '0;
        i_wake_pin = 1'b0;
        error_cnt  = 0;
        tests_run  = 0;
        repeat (6) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        // Reset values and reserved slots
        rd_chk(dcr_pkg::OFF_MODE, 32'hC800_0468);
        rd_chk(dcr_pkg::OFF_TSPRE, 32'h0000_0002);
        rd_chk(dcr_pkg::OFF_IEN, 32'h0FFF_FFFF);
        for (int i = 0; i < 7; i++) begin
            rd_chk(ZERO_A[i], 32'h0000_0000);
        end
        $display("TB: test reset_map done");
        // Writes: scratch, out of range, read-only and reserved places
        u_host.write_word(dcr_pkg::OFF_SCRATCH, 32'hA5A5_5A5A);
        u_host.write_word(16'h0908, 32'h1234_5678);
        u_host.write_word(16'h0814, 32'hFFFF_FFFF);
        u_host.write_word(dcr_pkg::OFF_DIFLAG, 32'hFFFF_FFFF);
        u_host.write_word(dcr_pkg::OFF_MODE, 32'hC800_0468 | 32'h0710_1030);
        rd_chk(dcr_pkg::OFF_SCRATCH, 32'hA5A5_5A5A);
        rd_chk(16'h0814, 32'h0000_0000);
        rd_chk(16'h0908, 32'h0000_0000);
        rd_chk(dcr_pkg::OFF_DIFLAG, 32'h0000_0000);
        rd_chk(dcr_pkg::OFF_MODE, 32'hC800_0468);
        $display("TB: test writes done");
        // Faults and interrupt level
        @(negedge i_sys_clk);
        i_int_fault = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk_word({29'h0, o_status}, 32'h0000_0004, "int fault");
        i_int_fault = 1'b0;
        i_spi_fault = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        chk_word({29'h0, o_status}, 32'h0000_0002, "spi fault");
        i_spi_fault = 1'b0;
        u_host.write_word(dcr_pkg::OFF_IEN, 32'h0000_4000);
        i_dev_flags = 32'h002F_0001;
        @(negedge i_sys_clk);
        i_dev_flags = 32'h0000_0000;
        repeat (2) @(negedge i_sys_clk);
        chk_bit(o_irq, 1'b0, "masked irq");
        chk_bit(o_status[0], 1'b0, "masked status");
        u_host.write_word(dcr_pkg::OFF_IEN, 32'h0020_4000);
        repeat (2) @(negedge i_sys_clk);
        chk_bit(o_irq, 1'b1, "irq");
        chk_bit(o_status[0], 1'b1, "irq status");
        $display("TB: test status done");
        // Sleep retention
        v = 32'h7800_0768;
        u_host.write_word(dcr_pkg::OFF_MODE, v);
        rd_chk(dcr_pkg::OFF_MODE, v);
        pulse_sleep();
        // Kept bits from the written word, the rest back to reset value
        v = 32'h4800_0768;
        rd_chk(dcr_pkg::OFF_MODE, v);
        chk_word(o_mode_cfg, v, "mode out");
        rd_chk(dcr_pkg::OFF_DIFLAG, 32'h002C_0000);
        rd_chk(dcr_pkg::OFF_IEN, 32'h0FFF_7FFF);
        @(negedge i_sys_clk);
        i_flag_clr = 1'b1;
        @(negedge i_sys_clk);
        i_flag_clr = 1'b0;
        @(negedge i_sys_clk);
        chk_bit(o_irq, 1'b0, "irq cleared");
        i_core_flags = 32'h0000_0001;
        @(negedge i_sys_clk);
        i_core_flags = 32'h0000_0000;
        chk_bit(o_irq, 1'b1, "core irq");
        $display("TB: test sleep done");
        // Wake edge selection, all four codes
        for (int s = 0; s < 4; s++) begin
            u_host.write_word(dcr_pkg::OFF_MODE,
                              {s[1:0], dcr_pkg::RST_MODE[29:0]});
            wake_try(1'b1, s[0]);
            wake_try(1'b0, s[1]);
        end
        $display("TB: test wake done");
        test_done();
    end
endmodule
